//--- eadp_pkg.sv
// Package: register map, field layout, timing counts and carriers of the E1 alarm block
package eadp_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_ALARM_STATE    = 8'hB9;
  localparam logic [7:0] IDX_ALARM_IRQ_EN   = 8'hBA;
  localparam logic [7:0] IDX_ALARM_CHANGED  = 8'hBB;
  localparam logic [7:0] IDX_ALARM_CRIT     = 8'hBC;
  localparam logic [7:0] IDX_MON_CTRL       = 8'hC2;
  localparam logic [7:0] IDX_MON_OVF_IRQ_EN = 8'hC3;
  localparam logic [7:0] IDX_MON_OVF_FLAGS  = 8'hC5;

  localparam int ADDR_W  = 10;
  localparam int DATA_W  = 32;
  localparam int ALARM_N = 6;

  // Alarm bit positions, shared by state, enable and change registers
  localparam int B_SLOT16_LOSS = 5;
  localparam int B_SLOT16_AIS  = 4;
  localparam int B_REMOTE_MF   = 3;
  localparam int B_ALL_ONES    = 2;
  localparam int B_REMOTE      = 1;
  localparam int B_FRAME_LOSS  = 0;

  localparam int B_ALL_ONES_CRIT = 1;
  localparam int B_REMOTE_CRIT   = 0;
  localparam int B_MANUAL_REFR   = 1;
  localparam int B_PERIODIC_EN   = 0;
  localparam int B_PATTERN_OVF   = 7;
  localparam int B_FAR_END_OVF   = 6;

  localparam logic [7:0] RST_BYTE = 8'h00;

  // Detection thresholds
  localparam logic [4:0] SLOT16_RUN     = 5'h10;
  localparam logic [3:0] SLOT16_PERIOD  = 4'hF;
  localparam logic [2:0] SLOT16_FEW     = 3'h4;
  localparam logic [1:0] REMOTE_MF_RUN  = 2'h3;
  localparam logic [2:0] REMOTE_RUN     = 3'h4;
  localparam logic [8:0] WINDOW_LAST    = 9'h1FF;
  localparam logic [1:0] WINDOW_FEW     = 2'h3;

  // Timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int RED_TIME_MS   = 100;
  localparam int SEC_TIME_MS   = 1000;
  localparam int RED_CYC       = (CLK_HZ / 1000) * RED_TIME_MS;
  localparam int SEC_CYC       = (CLK_HZ / 1000) * SEC_TIME_MS;
  localparam int RED_W         = 23;
  localparam int SEC_W         = 26;

  // Framed receive stream from the framer, same clock
  typedef struct packed {
    logic       basic_aligned;
    logic       mf_aligned;
    logic       line_valid;
    logic       line_bit;
    logic       slot16_valid;
    logic [7:0] slot16_byte;
    logic       a_valid;
    logic       a_bit;
    logic       y_valid;
    logic       y_bit;
  } eadp_rx_s;

  typedef struct packed {
    logic                ack;
    logic [DATA_W-1:0]   rdata;
    logic [ALARM_N-1:0]  alarm;
    logic [ALARM_N-1:0]  irq_en;
    logic [ALARM_N-1:0]  changed;
    logic [1:0]          crit;
    logic [1:0]          mon_ctrl;
    logic [7:0]          ovf_en;
    logic [1:0]          ovf_flag;
    logic [4:0]          los_zrun;
    logic [4:0]          los_nrun;
    logic [3:0]          s16_frm;
    logic [2:0]          s16_zero;
    logic                s16_prev_low;
    logic [1:0]          rma_run;
    logic [2:0]          rai_run;
    logic [8:0]          win_bit;
    logic [1:0]          win_zero;
    logic                win_prev_few;
    logic                win_prev_many;
    logic [RED_W-1:0]    red_cnt;
    logic [SEC_W-1:0]    sec_cnt;
    logic                refr_prev;
    logic                latch;
  } eadp_state_s;

endpackage : eadp_pkg

//--- eadp_alarm_top.sv
// E1 receive alarm detection, change flags, interrupt and monitor refresh control
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Slot-16 loss set after 16 consecutive all-zero slot-16 bytes while aligned.
// - Slot-16 loss cleared after 16 consecutive non-zero slot-16 bytes.
// - Slot-16 AIS set when two successive 16-frame periods each hold under 4 zeros.
// - Slot-16 AIS cleared when one 16-frame period holds more than 3 zeros.
// - Remote multiframe alarm set on 3 Y ones, cleared on one Y zero.
// - Criterion 0: AIS set on window under 3 zeros while unaligned, cleared above 2.
// - Criterion 1: AIS set or cleared after two consecutive matching windows.
// - Remote criterion 0: set after 4 A ones, cleared on one A zero.
// - Remote criterion 1: set on one A one, cleared on one A zero.
// - A bits only evaluated while basic frame alignment holds.
// - Red alarm set after 100 ms continuous loss of alignment.
// - Red alarm cleared after 100 ms continuous alignment.
// - Any change of an alarm state sets its change flag.
// - Writing one clears a change flag; zero writes leave it.
// - Active-low interrupt when an enabled change flag is set.
// - Rising edge of manual refresh bit latches monitor counts.
// - Periodic refresh enabled latches monitor counts every second, else none.
// - Pattern and far-end overflow flags reach interrupt only when enabled.
//////////////////////////////////////////////////////////////////////////////
//
// The Avalon-MM register port is this design's own decision.
module eadp_alarm_top
  import eadp_pkg::*;
#(
  parameter int unsigned RED_CYCLES = RED_CYC,
  parameter int unsigned SEC_CYCLES = SEC_CYC
)(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [DATA_W-1:0] avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire eadp_rx_s          rx_i,
  input  wire logic              pattern_err_overflow_i,
  input  wire logic              tx_far_end_err_overflow_i,
  output logic                   monitor_latch_o,
  output logic                   irq_b_o
);

  localparam logic [RED_W-1:0] RED_LAST = RED_W'(RED_CYCLES - 1);
  localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);

  eadp_state_s st_r;
  eadp_state_s st_nxt;

  logic [7:0] idx;
  logic       req;
  logic       wr_go;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;
  logic       irq_any;

  assign idx     = avs_address_i[ADDR_W-1:2];
  assign req     = avs_read_i | avs_write_i;
  assign wr_go   = avs_write_i & st_r.ack & avs_byteenable_i[0];
  assign wbyte   = avs_writedata_i[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped indices read zero
  always_comb
  begin
    rd_mux = RST_BYTE;
    case (idx)
      IDX_ALARM_STATE:    rd_mux = {2'h0, st_r.alarm};
      IDX_ALARM_IRQ_EN:   rd_mux = {2'h0, st_r.irq_en};
      IDX_ALARM_CHANGED:  rd_mux = {2'h0, st_r.changed};
      IDX_ALARM_CRIT:     rd_mux = {6'h00, st_r.crit};
      IDX_MON_CTRL:       rd_mux = {6'h00, st_r.mon_ctrl};
      IDX_MON_OVF_IRQ_EN: rd_mux = st_r.ovf_en;
      IDX_MON_OVF_FLAGS:  rd_mux = {st_r.ovf_flag, 6'h00};
      default:            rd_mux = RST_BYTE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic [3:0] byte_zeros;
    logic [3:0] s16_sum;
    logic       s16_low;
    logic [2:0] win_sum;
    logic       win_few;
    logic       a_ok;
    byte_zeros = 4'h0;
    s16_sum    = 4'h0;
    s16_low    = 1'b0;
    win_sum    = 3'h0;
    win_few    = 1'b0;
    a_ok       = 1'b0;
    st_nxt     = st_r;

    // Bus: one wait cycle, then answer with data captured on the first cycle
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack)
    begin
      st_nxt.rdata = {24'h000000, rd_mux};
    end

    if (wr_go)
    begin
      case (idx)
        IDX_ALARM_IRQ_EN:   st_nxt.irq_en = wbyte[ALARM_N-1:0];
        IDX_ALARM_CRIT:     st_nxt.crit = wbyte[1:0];
        IDX_MON_CTRL:       st_nxt.mon_ctrl = wbyte[1:0];
        IDX_MON_OVF_IRQ_EN: st_nxt.ovf_en = wbyte;
        default:            st_nxt.crit = st_r.crit;
      endcase
    end

    // Slot-16 loss
    if (rx_i.slot16_valid && rx_i.basic_aligned)
    begin
      if (rx_i.slot16_byte == 8'h00)
      begin
        st_nxt.los_nrun = 5'h00;
        if (st_r.los_zrun != SLOT16_RUN)
        begin
          st_nxt.los_zrun = st_r.los_zrun + 5'h01;
        end
        if (st_r.los_zrun >= SLOT16_RUN - 5'h01)
        begin
          st_nxt.alarm[B_SLOT16_LOSS] = 1'b1;
        end
      end
      else
      begin
        st_nxt.los_zrun = 5'h00;
        if (st_r.los_nrun != SLOT16_RUN)
        begin
          st_nxt.los_nrun = st_r.los_nrun + 5'h01;
        end
        if (st_r.los_nrun >= SLOT16_RUN - 5'h01)
        begin
          st_nxt.alarm[B_SLOT16_LOSS] = 1'b0;
        end
      end
    end

    // Slot-16 AIS over 16-frame periods; zeros saturate at four
    if (rx_i.slot16_valid && rx_i.basic_aligned)
    begin
      byte_zeros = 4'($countones(~rx_i.slot16_byte));
      s16_sum    = {1'b0, st_r.s16_zero} + byte_zeros;
      st_nxt.s16_zero = (s16_sum >= {1'b0, SLOT16_FEW}) ? SLOT16_FEW : s16_sum[2:0];
      st_nxt.s16_frm  = st_r.s16_frm + 4'h1;
      if (st_r.s16_frm == SLOT16_PERIOD)
      begin
        s16_low = s16_sum < {1'b0, SLOT16_FEW};
        st_nxt.s16_zero     = 3'h0;
        st_nxt.s16_prev_low = s16_low;
        if (s16_low && st_r.s16_prev_low)
        begin
          st_nxt.alarm[B_SLOT16_AIS] = 1'b1;
        end
        else if (!s16_low)
        begin
          st_nxt.alarm[B_SLOT16_AIS] = 1'b0;
        end
      end
    end

    // Remote multiframe alarm from Y bits
    if (rx_i.y_valid && rx_i.mf_aligned)
    begin
      if (rx_i.y_bit)
      begin
        if (st_r.rma_run != REMOTE_MF_RUN)
        begin
          st_nxt.rma_run = st_r.rma_run + 2'h1;
        end
        if (st_r.rma_run >= REMOTE_MF_RUN - 2'h1)
        begin
          st_nxt.alarm[B_REMOTE_MF] = 1'b1;
        end
      end
      else
      begin
        st_nxt.rma_run = 2'h0;
        st_nxt.alarm[B_REMOTE_MF] = 1'b0;
      end
    end

    // Remote alarm from A bits
    a_ok = rx_i.a_valid & rx_i.basic_aligned;
    if (a_ok)
    begin
      if (rx_i.a_bit)
      begin
        if (st_r.rai_run != REMOTE_RUN)
        begin
          st_nxt.rai_run = st_r.rai_run + 3'h1;
        end
        if (st_r.crit[B_REMOTE_CRIT])
        begin
          st_nxt.alarm[B_REMOTE] = 1'b1;
        end
        else if (st_r.rai_run >= REMOTE_RUN - 3'h1)
        begin
          st_nxt.alarm[B_REMOTE] = 1'b1;
        end
      end
      else
      begin
        st_nxt.rai_run = 3'h0;
        st_nxt.alarm[B_REMOTE] = 1'b0;
      end
    end

    // All-ones over fixed 512-bit windows
    if (rx_i.line_valid)
    begin
      win_sum = {1'b0, st_r.win_zero} + {2'h0, ~rx_i.line_bit};
      st_nxt.win_zero = (win_sum >= {1'b0, WINDOW_FEW}) ? WINDOW_FEW : win_sum[1:0];
      st_nxt.win_bit  = st_r.win_bit + 9'h001;
      if (st_r.win_bit == WINDOW_LAST)
      begin
        win_few = win_sum < {1'b0, WINDOW_FEW};
        st_nxt.win_zero      = 2'h0;
        st_nxt.win_prev_few  = win_few;
        st_nxt.win_prev_many = ~win_few;
        if (!st_r.crit[B_ALL_ONES_CRIT])
        begin
          if (win_few && !rx_i.basic_aligned)
          begin
            st_nxt.alarm[B_ALL_ONES] = 1'b1;
          end
          else if (!win_few)
          begin
            st_nxt.alarm[B_ALL_ONES] = 1'b0;
          end
        end
        else
        begin
          if (win_few && st_r.win_prev_few)
          begin
            st_nxt.alarm[B_ALL_ONES] = 1'b1;
          end
          else if (!win_few && st_r.win_prev_many)
          begin
            st_nxt.alarm[B_ALL_ONES] = 1'b0;
          end
        end
      end
    end

    // Red alarm: count while alignment disagrees with the alarm
    if (rx_i.basic_aligned == st_r.alarm[B_FRAME_LOSS])
    begin
      if (st_r.red_cnt == RED_LAST)
      begin
        st_nxt.red_cnt = '0;
        st_nxt.alarm[B_FRAME_LOSS] = ~rx_i.basic_aligned;
      end
      else
      begin
        st_nxt.red_cnt = st_r.red_cnt + RED_W'(1);
      end
    end
    else
    begin
      st_nxt.red_cnt = '0;
    end

    // Change flags: set beats a same-cycle clear
    st_nxt.changed = (st_r.changed & ~((wr_go && idx == IDX_ALARM_CHANGED) ? wbyte[ALARM_N-1:0] : '0))
                   | (st_nxt.alarm ^ st_r.alarm);
    st_nxt.ovf_flag = (st_r.ovf_flag & ~((wr_go && idx == IDX_MON_OVF_FLAGS) ? wbyte[7:6] : 2'h0))
                    | {pattern_err_overflow_i, tx_far_end_err_overflow_i};

    // Monitor refresh
    st_nxt.refr_prev = st_r.mon_ctrl[B_MANUAL_REFR];
    st_nxt.latch     = st_r.mon_ctrl[B_MANUAL_REFR] & ~st_r.refr_prev;
    if (!st_r.mon_ctrl[B_PERIODIC_EN])
    begin
      st_nxt.sec_cnt = '0;
    end
    else if (st_r.sec_cnt == SEC_LAST)
    begin
      st_nxt.sec_cnt = '0;
      st_nxt.latch   = 1'b1;
    end
    else
    begin
      st_nxt.sec_cnt = st_r.sec_cnt + SEC_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign irq_any = |(st_r.changed & st_r.irq_en)
                 | (st_r.ovf_flag[1] & st_r.ovf_en[B_PATTERN_OVF])
                 | (st_r.ovf_flag[0] & st_r.ovf_en[B_FAR_END_OVF]);
  assign irq_b_o           = ~irq_any;
  assign avs_waitrequest_o = req & ~st_r.ack;
  assign avs_readdata_o    = st_r.rdata;
  assign monitor_latch_o   = st_r.latch;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_LOS_SET: assert property (
    rx_i.slot16_valid && rx_i.basic_aligned && rx_i.slot16_byte == 8'h00 && st_r.los_zrun >= 5'h0F
    |=> st_r.alarm[B_SLOT16_LOSS])
    else $error("slot16 loss not set after 16 zero bytes");

  AST_LOS_CLR: assert property (
    $fell(st_r.alarm[B_SLOT16_LOSS]) |-> $past(st_r.los_nrun) == 5'h0F)
    else $error("slot16 loss cleared early");

  AST_S16AIS_SET: assert property (
    $rose(st_r.alarm[B_SLOT16_AIS]) |-> $past(st_r.s16_prev_low) && $past(st_r.s16_frm) == SLOT16_PERIOD)
    else $error("slot16 AIS set without two low periods");

  AST_RMA_CLR: assert property (
    rx_i.y_valid && rx_i.mf_aligned && !rx_i.y_bit |=> !st_r.alarm[B_REMOTE_MF])
    else $error("remote multiframe alarm not cleared");

  AST_RAI_C0: assert property (
    $rose(st_r.alarm[B_REMOTE]) && !$past(st_r.crit[B_REMOTE_CRIT]) |-> $past(st_r.rai_run) >= 3'h3)
    else $error("remote alarm set before 4 ones");

  AST_RAI_ALIGN: assert property (
    $changed(st_r.alarm[B_REMOTE]) |-> $past(rx_i.basic_aligned && rx_i.a_valid))
    else $error("remote alarm moved while unaligned");

  AST_AIS_C0: assert property (
    $rose(st_r.alarm[B_ALL_ONES]) && !$past(st_r.crit[B_ALL_ONES_CRIT]) |-> !$past(rx_i.basic_aligned))
    else $error("AIS declared while aligned");

  AST_RED_TIME: assert property (
    $changed(st_r.alarm[B_FRAME_LOSS]) |-> $past(st_r.red_cnt) == RED_LAST)
    else $error("red alarm timing wrong");

  AST_FLAG_SET: assert property (
    $changed(st_r.alarm) |-> (st_r.changed & (st_r.alarm ^ $past(st_r.alarm))) == (st_r.alarm ^ $past(st_r.alarm)))
    else $error("change flag missing");

  AST_IRQ: assert property (
    $changed(st_r.alarm[B_REMOTE]) && st_r.irq_en[B_REMOTE] |-> !irq_b_o ##1 1'b1)
    else $error("interrupt not raised");

  AST_MANUAL: assert property (
    $rose(st_r.mon_ctrl[B_MANUAL_REFR]) |=> monitor_latch_o)
    else $error("manual refresh lost");

  AST_NO_AUTO: assert property (
    !st_r.mon_ctrl[B_PERIODIC_EN] && !st_r.mon_ctrl[B_MANUAL_REFR] [*2] |=> !monitor_latch_o)
    else $error("refresh without request");

  COV_LOS:  cover property ($rose(st_r.alarm[B_SLOT16_LOSS]));
  COV_AIS:  cover property ($rose(st_r.alarm[B_ALL_ONES]));
  COV_RED:  cover property ($rose(st_r.alarm[B_FRAME_LOSS]));
  COV_AUTO: cover property (st_r.mon_ctrl[B_PERIODIC_EN] && monitor_latch_o);

endmodule : eadp_alarm_top

//--- eadp_rx_model.sv
// Far-end framer model driving the framed E1 receive stream
module eadp_rx_model
  import eadp_pkg::*;
(
  input  wire logic clk_i,
  output eadp_rx_s  rx_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rx_o = '0;

  task automatic align(input logic basic, input logic mf);
    @(posedge clk_i);
    rx_o.basic_aligned <= basic;
    rx_o.mf_aligned    <= mf;
  endtask : align

  // Strobes drop and data inverts, so stale data never passes for a fresh unit
  task automatic idle();
    @(posedge clk_i);
    rx_o.slot16_valid <= 1'b0;
    rx_o.a_valid      <= 1'b0;
    rx_o.y_valid      <= 1'b0;
    rx_o.line_valid   <= 1'b0;
    rx_o.slot16_byte  <= ~rx_o.slot16_byte;
    rx_o.a_bit        <= ~rx_o.a_bit;
    rx_o.y_bit        <= ~rx_o.y_bit;
    rx_o.line_bit     <= ~rx_o.line_bit;
  endtask : idle

  // Kind 0 slot-16 byte, 1 A bit, 2 Y bit, 3 line bit; gap idles after each unit
  task automatic strobe(input int kind, input logic [7:0] d, input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      rx_o.slot16_valid <= (kind == 0);
      rx_o.a_valid      <= (kind == 1);
      rx_o.y_valid      <= (kind == 2);
      rx_o.line_valid   <= (kind == 3);
      rx_o.slot16_byte  <= d;
      rx_o.a_bit        <= d[0];
      rx_o.y_bit        <= d[0];
      rx_o.line_bit     <= d[0];
      repeat (gap) idle();
    end
    idle();
  endtask : strobe
endmodule : eadp_rx_model

//--- tb.sv
// Self-checking bench: register bus, alarm detection, interrupt and refresh control
module tb;
  import eadp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int RED_N = 20;
  localparam int SEC_N = 50;
  localparam logic [7:0] RW_IDX [3] = '{IDX_ALARM_IRQ_EN, IDX_ALARM_CRIT, IDX_MON_OVF_IRQ_EN};
  localparam logic [7:0] RW_MSK [3] = '{8'h3F, 8'h03, 8'hFF};
  localparam logic [7:0] RST_IDX [8] = '{IDX_ALARM_STATE, IDX_ALARM_IRQ_EN, IDX_ALARM_CHANGED,
    IDX_ALARM_CRIT, IDX_MON_CTRL, IDX_MON_OVF_IRQ_EN, IDX_MON_OVF_FLAGS, 8'h10};

  logic              clk_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic              avs_read_i = 1'b0;
  logic              avs_write_i = 1'b0;
  logic [DATA_W-1:0] avs_writedata_i = '0;
  logic [3:0]        avs_byteenable_i = 4'hF;
  logic [DATA_W-1:0] avs_readdata_o;
  logic              avs_waitrequest_o;
  eadp_rx_s          rx_i;
  logic              pattern_err_overflow_i = 1'b0;
  logic              tx_far_end_err_overflow_i = 1'b0;
  logic              monitor_latch_o;
  logic              irq_b_o;
  int                n_mismatch = 0;
  int                n_tests = 0;
  int                n_latch = 0;
  int                g;
  logic [7:0]        v;
  logic [63:0]       e;
  logic [63:0]       exp_q [$];

  eadp_alarm_top #(.RED_CYCLES(RED_N), .SEC_CYCLES(SEC_N)) eadp_alarm_top_i (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rx_i(rx_i),
    .pattern_err_overflow_i(pattern_err_overflow_i), .tx_far_end_err_overflow_i(tx_far_end_err_overflow_i),
    .monitor_latch_o(monitor_latch_o), .irq_b_o(irq_b_o));

  eadp_rx_model eadp_rx_model_i (.clk_i(clk_i), .rx_o(rx_i));

  always #10 clk_i = ~clk_i;

  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wrap_up();
    // A read that never got its answer is a mismatch too
    if (exp_q.size() != 0)
      n_mismatch++;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Latch pulse counted mid-cycle, clear of the edge that resets the count
  always @(negedge clk_i)
  begin
    if (monitor_latch_o === 1'b1)
      n_latch++;
  end

  // Read data taken at the accepting edge, before that edge updates the block
  always @(posedge clk_i)
  begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      cmp(avs_readdata_o & e[31:0], e[63:32]);
    end
  end

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [15:0] em);
    if (!wr)
      exp_q.push_back({24'h000000, em[15:8], 24'hFFFFFF, em[7:0]});
    @(posedge clk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_writedata_i <= {24'h000000, d};
    avs_read_i      <= !wr;
    avs_write_i     <= wr;
    // Request held until the edge that sees waitrequest low; only the watchdog ends a hang
    do
      @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0);
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 16'h0000);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] msk);
    bus(1'b0, idx, 8'h00, {exp, msk});
  endtask : rd

  task automatic chk_irq(input logic exp);
    @(negedge clk_i);
    cmp({31'h0, irq_b_o}, {31'h0, exp});
  endtask : chk_irq

  task automatic s(input int kind, input logic [7:0] d, input int n);
    eadp_rx_model_i.strobe(kind, d, n, g);
  endtask : s

  task automatic win(input int nz);
    for (int i = 0; i < 512; i++)
      eadp_rx_model_i.strobe(3, (i < nz) ? 8'h00 : 8'h01, 1, 0);
  endtask : win

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(5));
    g = $urandom_range(2);
    eadp_rx_model_i.align(1'b1, 1'b1);
    repeat (11) @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (RST_IDX[i]) rd(RST_IDX[i], RST_BYTE, 8'hFF);
    for (int i = 0; i < 3; i++)
    begin
      v = 8'($urandom);
      wr(RW_IDX[i], v);
      rd(RW_IDX[i], v & RW_MSK[i], 8'hFF);
      avs_byteenable_i <= 4'h0;
      wr(RW_IDX[i], ~v);
      avs_byteenable_i <= 4'hF;
      rd(RW_IDX[i], v & RW_MSK[i], 8'hFF);
      wr(RW_IDX[i], 8'h00);
    end
    wr(IDX_ALARM_STATE, 8'hFF);
    wr(8'h10, 8'hFF);
    rd(IDX_ALARM_STATE, 8'h00, 8'hFF);
    rd(8'h10, 8'h00, 8'hFF);
    // Frame loss persistence both ways, then interrupt masking and clearing
    eadp_rx_model_i.align(1'b0, 1'b1);
    repeat (RED_N / 2) @(posedge clk_i);
    rd(IDX_ALARM_STATE, 8'h00, 8'h01);
    repeat (RED_N) @(posedge clk_i);
    rd(IDX_ALARM_STATE, 8'h01, 8'h01);
    rd(IDX_ALARM_CHANGED, 8'h01, 8'h3F);
    wr(IDX_ALARM_CHANGED, 8'h01);
    eadp_rx_model_i.align(1'b1, 1'b1);
    repeat (RED_N / 2) @(posedge clk_i);
    rd(IDX_ALARM_STATE, 8'h01, 8'h01);
    repeat (RED_N) @(posedge clk_i);
    rd(IDX_ALARM_STATE, 8'h00, 8'h01);
    chk_irq(1'b1);
    wr(IDX_ALARM_IRQ_EN, 8'h01);
    chk_irq(1'b0);
    wr(IDX_ALARM_CHANGED, 8'h00);
    rd(IDX_ALARM_CHANGED, 8'h01, 8'hFF);
    wr(IDX_ALARM_CHANGED, 8'h3F);
    rd(IDX_ALARM_CHANGED, 8'h00, 8'hFF);
    chk_irq(1'b1);
    wr(IDX_ALARM_IRQ_EN, 8'h00);
    for (int b = 6; b < 8; b++)
    begin
      @(posedge clk_i);
      pattern_err_overflow_i    <= (b == B_PATTERN_OVF);
      tx_far_end_err_overflow_i <= (b == B_FAR_END_OVF);
      @(posedge clk_i);
      pattern_err_overflow_i    <= 1'b0;
      tx_far_end_err_overflow_i <= 1'b0;
      chk_irq(1'b1);
      rd(IDX_MON_OVF_FLAGS, 8'(1 << b), 8'hFF);
      wr(IDX_MON_OVF_IRQ_EN, 8'(1 << b));
      chk_irq(1'b0);
      wr(IDX_MON_OVF_FLAGS, 8'(1 << b));
      rd(IDX_MON_OVF_FLAGS, 8'h00, 8'hFF);
      chk_irq(1'b1);
      wr(IDX_MON_OVF_IRQ_EN, 8'h00);
    end
    // Slot-16 loss and AIS with boundary zero counts of 3 and 4 per period
    s(0, 8'h00, 15);
    rd(IDX_ALARM_STATE, 8'h00, 8'h20);
    s(0, 8'h00, 1);
    rd(IDX_ALARM_STATE, 8'h20, 8'h30);
    s(0, 8'hFF, 15);
    rd(IDX_ALARM_STATE, 8'h20, 8'h20);
    s(0, 8'hFF, 1);
    rd(IDX_ALARM_STATE, 8'h00, 8'h30);
    s(0, 8'hF1, 1);
    s(0, 8'hFF, 15);
    rd(IDX_ALARM_STATE, 8'h10, 8'h30);
    s(0, 8'hF0, 1);
    s(0, 8'hFF, 14);
    rd(IDX_ALARM_STATE, 8'h10, 8'h10);
    s(0, 8'hFF, 1);
    rd(IDX_ALARM_STATE, 8'h00, 8'h30);
    // Remote alarm under both criteria, and A bits while unaligned
    s(1, 8'h01, 3);
    rd(IDX_ALARM_STATE, 8'h00, 8'h02);
    s(1, 8'h01, 1);
    rd(IDX_ALARM_STATE, 8'h02, 8'h02);
    s(1, 8'h00, 1);
    rd(IDX_ALARM_STATE, 8'h00, 8'h02);
    eadp_rx_model_i.align(1'b0, 1'b1);
    eadp_rx_model_i.strobe(1, 8'h01, 4, 0);
    eadp_rx_model_i.align(1'b1, 1'b1);
    rd(IDX_ALARM_STATE, 8'h00, 8'h02);
    wr(IDX_ALARM_CRIT, 8'h01);
    s(1, 8'h01, 1);
    rd(IDX_ALARM_STATE, 8'h02, 8'h02);
    s(1, 8'h00, 1);
    rd(IDX_ALARM_STATE, 8'h00, 8'h02);
    s(2, 8'h01, 2);
    rd(IDX_ALARM_STATE, 8'h00, 8'h08);
    s(2, 8'h01, 1);
    rd(IDX_ALARM_STATE, 8'h08, 8'h08);
    s(2, 8'h00, 1);
    rd(IDX_ALARM_STATE, 8'h00, 8'h08);
    // AIS windows: 2 zeros is few, 3 zeros is many
    wr(IDX_ALARM_CRIT, 8'h00);
    win(0);
    rd(IDX_ALARM_STATE, 8'h00, 8'h04);
    eadp_rx_model_i.align(1'b0, 1'b1);
    win(2);
    rd(IDX_ALARM_STATE, 8'h04, 8'h04);
    win(3);
    rd(IDX_ALARM_STATE, 8'h00, 8'h04);
    wr(IDX_ALARM_CRIT, 8'h02);
    win(0);
    rd(IDX_ALARM_STATE, 8'h00, 8'h04);
    win(1);
    rd(IDX_ALARM_STATE, 8'h04, 8'h04);
    win(3);
    rd(IDX_ALARM_STATE, 8'h04, 8'h04);
    win(3);
    rd(IDX_ALARM_STATE, 8'h00, 8'h04);
    eadp_rx_model_i.align(1'b1, 1'b1);
    // Monitor refresh: only a rising manual bit, then periodic on and off
    n_latch = 0;
    wr(IDX_MON_CTRL, 8'h02);
    repeat (4) @(posedge clk_i);
    cmp(n_latch, 1);
    wr(IDX_MON_CTRL, 8'h02);
    repeat (4) @(posedge clk_i);
    cmp(n_latch, 1);
    wr(IDX_MON_CTRL, 8'h00);
    wr(IDX_MON_CTRL, 8'h02);
    repeat (4) @(posedge clk_i);
    cmp(n_latch, 2);
    wr(IDX_MON_CTRL, 8'h01);
    n_latch = 0;
    repeat (5 * SEC_N) @(posedge clk_i);
    cmp(32'(n_latch >= 4 && n_latch <= 6), 1);
    wr(IDX_MON_CTRL, 8'h00);
    n_latch = 0;
    repeat (3 * SEC_N) @(posedge clk_i);
    cmp(n_latch, 0);
    wrap_up();
  end
endmodule : tb
